//--- test/pfs_mem_model.sv
`timescale 1ns/100ps
// display memory stand-in: answers each read promptly or after a wait
module pfs_mem_model
	import pfs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic [19:0] mem_addr,
	input wire logic [2:0] mem_plane,
	output logic mem_ack,
	output logic [15:0] mem_data
);
	logic [1:0] wait_q;
	////////////////////////////////////////////////////////////////////////
	// one ack pulse per request; data changes every idle cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mem_ack <= 1'b0;
			wait_q <= 2'h0;
			mem_data <= 16'h0000;
		end else if (mem_req && !mem_ack && wait_q == (slow ? 2'h3 : 2'h0)) begin
			mem_ack <= 1'b1;
			wait_q <= 2'h0;
			mem_data <= mem_addr[16:1] ^ {13'h0000, mem_plane};
		end else begin
			mem_ack <= 1'b0;
			wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
			mem_data <= ~mem_data;
		end
	end
endmodule : pfs_mem_model

//--- test/playfield_scroll_fetch_tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	n_fail++; $display("BAD %0t got %h want %h", $time, got, exp); end end
// scroll fetch bench: register bus, fetch window, vblank gating
module playfield_scroll_fetch_tb_top;
	import pfs_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000;
	logic [31:0] araddr = 32'h0000_0000, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, sprite7_disable;
	logic [1:0] bresp, rresp;
	logic [8:0] hpos = 9'h000;
	logic line_start = 1'b0, vblank = 1'b1;
	logic mem_req, mem_ack;
	logic [19:0] mem_addr;
	logic [2:0] mem_plane;
	logic [15:0] mem_data;
	logic [PFS_NPLANES-1:0] pix_out;
	int n_fail = 0;
	int comparisons = 0;
	////////////////////////////////////////////////////////////////////////
	// clock and a 228-cycle line timebase
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		hpos <= (hpos == 9'h0E3) ? 9'h000 : hpos + 9'h001;
		line_start <= (hpos == 9'h0E3);
	end
	pfs_scroll_fetch #(.AW(20)) dut_u (.sys_clk(sys_clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .hpos(hpos), .line_start(line_start),
		.vblank(vblank), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_plane(mem_plane), .mem_ack(mem_ack), .mem_data(mem_data),
		.pix_out(pix_out), .sprite7_disable(sprite7_disable));
	pfs_mem_model mem_u (.sys_clk(sys_clk), .reset(reset), .slow(slow),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_plane(mem_plane),
		.mem_ack(mem_ack), .mem_data(mem_data));
	////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic results;
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	task automatic stop_run;
		n_fail++;
		results();
	endtask : stop_run
	// bus write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int i;
		@(posedge sys_clk);
		awaddr <= {24'h00_0000, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				`CHK(bresp, er)
				bready <= 1'b0;
				break;
			end
		end
		if (i == 100) stop_run();
	endtask : wr
	// bus read; data judged only on an OKAY answer
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int i;
		@(posedge sys_clk);
		araddr <= {24'h00_0000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				`CHK(rresp, er)
				if (er == PFS_RESP_OKAY) `CHK(rdata, ed)
				rready <= 1'b0;
				break;
			end
		end
		if (i == 100) stop_run();
	endtask : rd
	////////////////////////////////////////////////////////////////////////
	// reset values, write-only reads, unmapped places
	task automatic t_regs;
		rd(PFS_REG_DELAY, 32'h0000_0000, PFS_RESP_OKAY);
		rd(PFS_REG_FSTART, 32'h0000_0038, PFS_RESP_OKAY);
		rd(PFS_REG_FSTOP, 32'h0000_00D0, PFS_RESP_OKAY);
		`CHK(pix_out, 6'h00)
		rd(8'hFC, 32'h0000_0000, PFS_RESP_SLVERR);
		wr(8'hF8, 32'h0000_0000, PFS_RESP_SLVERR);
	endtask : t_regs
	// early fetch start gives up the last sprite slot
	task automatic t_sprite;
		wr(PFS_REG_FSTART, 32'h0000_0030, PFS_RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		`CHK(sprite7_disable, 1'b1)
		wr(PFS_REG_FSTART, 32'h0000_0038, PFS_RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		`CHK(sprite7_disable, 1'b0)
		wr(PFS_REG_FSTART, 32'h0000_0030, PFS_RESP_OKAY);
	endtask : t_sprite
	// one field: pointers set in blanking, one line step per field
	task automatic t_field(input int f, input logic sl);
		int i, n;
		slow <= sl;
		vblank <= 1'b1;
		for (n = 0; n < 6; n++)
			wr(PFS_REG_PTR0 + 8'(4 * n), 32'h1000 * (n + 1) + 40 * f,
				PFS_RESP_OKAY);
		@(posedge sys_clk);
		vblank <= 1'b0;
		n = 0;
		for (i = 0; i < 2000 && n < 6; i++) begin
			@(posedge sys_clk);
			if (mem_req && mem_ack) begin
				`CHK(mem_plane, 3'(n))
				`CHK(mem_addr, 20'(32'h1000 * (n + 1) + 40 * f))
				n++;
			end
		end
		if (n < 6) stop_run();
		vblank <= 1'b1;
	endtask : t_field
	// blanking holds off all display reads
	task automatic t_vblank;
		int i, cnt;
		cnt = 0;
		repeat (20) @(posedge sys_clk);
		for (i = 0; i < 300; i++) begin
			@(posedge sys_clk);
			if (mem_req) cnt++;
		end
		`CHK(cnt, 0)
	endtask : t_vblank
	// hires with one delay unit in both playfields, a line to take effect
	task automatic t_hires;
		wr(PFS_REG_CTRL, 32'h0000_0003, PFS_RESP_OKAY);
		wr(PFS_REG_DELAY, 32'h0000_0011, PFS_RESP_OKAY);
		repeat (240) @(posedge sys_clk);
		rd(PFS_REG_CTRL, 32'h0000_0003, PFS_RESP_OKAY);
	endtask : t_hires
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		t_regs();
		t_sprite();
		for (int n = 0; n < 6; n++)
			wr(PFS_REG_MOD0 + 8'(4 * n), 32'h0000_0026, PFS_RESP_OKAY);
		wr(PFS_REG_DELAY, 32'h0000_0077, PFS_RESP_OKAY);
		wr(PFS_REG_CTRL, 32'h0000_0002, PFS_RESP_OKAY);
		t_field(0, 1'b0);
		t_field(1, 1'b1);
		t_field(3, 1'b0);
		t_vblank();
		t_hires();
		results();
	end
endmodule : playfield_scroll_fetch_tb_top

//--- verilog/pfs_delay_line.sv
`timescale 1ns/100ps
// per-plane pixel delay: shift register tapped by delay count
module pfs_delay_line
	import pfs_pkg::*;
#(
	parameter int DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic bit_in,
	input wire logic [4:0] tap,
	output logic bit_out
);
	logic [DEPTH-1:0] sr_q;

	// shift history; tap 0 means no extra delay
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sr_q <= '0;
		end else begin
			sr_q <= {sr_q[DEPTH-2:0], bit_in};
		end
	end

	// delayed tap; tap zero passes straight through
	always_comb begin
		if (tap == 5'd0) begin
			bit_out = bit_in;
		end else begin
			bit_out = sr_q[tap - 5'd1];
		end
	end
endmodule : pfs_delay_line

//--- verilog/pfs_pkg.sv
package pfs_pkg;
	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] PFS_REG_DELAY = 8'h00;
	localparam logic [7:0] PFS_REG_FSTART = 8'h04;
	localparam logic [7:0] PFS_REG_FSTOP = 8'h08;
	localparam logic [7:0] PFS_REG_CTRL = 8'h0C;
	localparam logic [7:0] PFS_REG_STATUS = 8'h10;
	localparam logic [7:0] PFS_REG_MOD0 = 8'h20;
	localparam logic [7:0] PFS_REG_PTR0 = 8'h40;
	localparam int PFS_NPLANES = 6;
	// delay field layout
	localparam int PFS_PF1_LO = 0;
	localparam int PFS_PF2_LO = 4;
	localparam int PFS_DLY_W = 4;
	// fetch window reset values and sprite 7 boundary
	localparam logic [8:0] PFS_FSTART_RST = 9'h038;
	localparam logic [8:0] PFS_FSTOP_RST = 9'h0D0;
	localparam logic [8:0] PFS_FSTART_NORMAL = 9'h038;
	localparam logic [15:0] PFS_DELAY_RST = 16'h0000;
	localparam logic [1:0] PFS_RESP_OKAY = 2'b00;
	localparam logic [1:0] PFS_RESP_SLVERR = 2'b10;
	// control bits
	localparam int PFS_CTRL_HIRES = 0;
	localparam int PFS_CTRL_EN = 1;
endpackage : pfs_pkg

//--- verilog/pfs_scroll_fetch.sv
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Function
// - one extra word fetched per plane per line, output held back
// - horizontal delay 0..15 pixels, each shifts data one pixel right
// - in hires each delay unit moves data two hires pixels
// - extra word sits left of window, enters as delay grows
// - fetch start before normal value disables sprite 7 slot
// - one fetch window shared by all planes
// - modulo added to advanced pointer after last word of line
// - each plane uses its own modulo
// - delay bits 3-0 playfield 1, bits 7-4 playfield 2
module pfs_scroll_fetch
	import pfs_pkg::*;
#(
	parameter int AW = 20
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [8:0] hpos,
	input wire logic line_start,
	input wire logic vblank,
	output logic mem_req,
	output logic [AW-1:0] mem_addr,
	output logic [2:0] mem_plane,
	input wire logic mem_ack,
	input wire logic [15:0] mem_data,
	output logic [PFS_NPLANES-1:0] pix_out,
	output logic sprite7_disable
);
	typedef enum logic [1:0] {
		PFS_IDLE = 2'b00,
		PFS_FETCH = 2'b01,
		PFS_WAIT = 2'b10,
		PFS_MOD = 2'b11
	} pfs_state_t;

	logic [15:0] scroll_delay_control_q;
	logic [8:0] fetch_start_position_q, fetch_stop_position_q;
	logic [1:0] ctrl_q;
	logic [AW-1:0] plane_ptr_q [PFS_NPLANES];
	logic [15:0] plane_line_modulo_q [PFS_NPLANES];
	logic [7:0] line_delay_q;
	pfs_state_t state_q;
	logic [2:0] plane_q;
	logic last_word_q, in_window;
	logic [15:0] shreg_q [PFS_NPLANES];
	logic [15:0] hold_q [PFS_NPLANES];
	logic [3:0] pix_cnt_q;
	logic [PFS_NPLANES-1:0] dly_out;
	logic aw_got_q, w_got_q;
	logic [7:0] aw_q;
	logic [31:0] wd_q;

	// index of plane register in a block of six words
	function automatic logic [3:0] reg_idx(input logic [7:0] a,
		input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		if (a >= base && d[7:2] < PFS_NPLANES && d[1:0] == 2'b00) begin
			reg_idx = {1'b0, d[4:2]};
		end else begin
			reg_idx = 4'hF;
		end
	endfunction : reg_idx

	////////////////////////////////////////////////////////////////////////
	// axi write channel: take address and data in either order
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PFS_RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (aw_got_q && w_got_q) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bresp <= (aw_q <= PFS_REG_STATUS && aw_q[1:0] == 2'b00) ||
				reg_idx(aw_q, PFS_REG_MOD0) != 4'hF ||
				reg_idx(aw_q, PFS_REG_PTR0) != 4'hF ? PFS_RESP_OKAY
				: PFS_RESP_SLVERR;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_q <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wd_q <= s_axi_wdata;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// ready drops on a take, returns once the response is gone
			s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready)
				&& !(s_axi_bvalid && !s_axi_bready);
			s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready)
				&& !(s_axi_bvalid && !s_axi_bready);
		end
	end

	// register file writes (software keeps to vertical blanking)
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			scroll_delay_control_q <= PFS_DELAY_RST;
			fetch_start_position_q <= PFS_FSTART_RST;
			fetch_stop_position_q <= PFS_FSTOP_RST;
			ctrl_q <= '0;
		end else if (aw_got_q && w_got_q) begin
			case (aw_q)
				PFS_REG_DELAY: scroll_delay_control_q <= wd_q[15:0];
				PFS_REG_FSTART: fetch_start_position_q <= wd_q[8:0];
				PFS_REG_FSTOP: fetch_stop_position_q <= wd_q[8:0];
				PFS_REG_CTRL: ctrl_q <= wd_q[1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi read channel
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= PFS_RESP_OKAY;
			s_axi_arready <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rresp <= PFS_RESP_OKAY;
			case (s_axi_araddr[7:0])
				PFS_REG_FSTART: s_axi_rdata <= {23'h0, fetch_start_position_q};
				PFS_REG_FSTOP: s_axi_rdata <= {23'h0, fetch_stop_position_q};
				PFS_REG_CTRL: s_axi_rdata <= {30'h0, ctrl_q};
				PFS_REG_STATUS: s_axi_rdata <= {28'h0, sprite7_disable,
					state_q, in_window};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= (s_axi_araddr[7:0] == PFS_REG_DELAY) ||
						reg_idx(s_axi_araddr[7:0], PFS_REG_MOD0) != 4'hF ||
						reg_idx(s_axi_araddr[7:0], PFS_REG_PTR0) != 4'hF
						? PFS_RESP_OKAY : PFS_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared fetch window for all planes
	assign in_window = hpos >= fetch_start_position_q &&
		hpos <= fetch_stop_position_q;

	// early fetch start steals the last sprite slot
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sprite7_disable <= 1'b0;
		end else begin
			sprite7_disable <= fetch_start_position_q < PFS_FSTART_NORMAL;
		end
	end

	// fetch sequencer: one word per plane per slot, modulo at line end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= PFS_IDLE;
			plane_q <= '0;
			last_word_q <= 1'b0;
			mem_req <= 1'b0;
			mem_addr <= '0;
			mem_plane <= '0;
			for (int i = 0; i < PFS_NPLANES; i++) begin
				plane_ptr_q[i] <= '0;
				plane_line_modulo_q[i] <= '0;
			end
		end else begin
			if (aw_got_q && w_got_q) begin
				for (int i = 0; i < PFS_NPLANES; i++) begin
					if (reg_idx(aw_q, PFS_REG_MOD0) == i) begin
						plane_line_modulo_q[i] <= wd_q[15:0];
					end
					if (reg_idx(aw_q, PFS_REG_PTR0) == i) begin
						plane_ptr_q[i] <= wd_q[AW-1:0];
					end
				end
			end
			// a burst that runs across the stop position ends the line
			if (state_q != PFS_IDLE && hpos == fetch_stop_position_q) begin
				last_word_q <= 1'b1;
			end
			case (state_q)
				PFS_IDLE: begin
					if (ctrl_q[PFS_CTRL_EN] && in_window && !vblank) begin
						state_q <= PFS_FETCH;
						plane_q <= '0;
						last_word_q <= hpos >= fetch_stop_position_q;
					end
				end
				PFS_FETCH: begin
					mem_req <= 1'b1;
					mem_addr <= plane_ptr_q[plane_q];
					mem_plane <= plane_q;
					state_q <= PFS_WAIT;
				end
				PFS_WAIT: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						plane_ptr_q[plane_q] <= plane_ptr_q[plane_q] +
							AW'(2);
						if (plane_q == 3'(PFS_NPLANES - 1)) begin
							state_q <= last_word_q ? PFS_MOD : PFS_IDLE;
						end else begin
							plane_q <= plane_q + 3'd1;
							state_q <= PFS_FETCH;
						end
					end
				end
				PFS_MOD: begin
					for (int i = 0; i < PFS_NPLANES; i++) begin
						plane_ptr_q[i] <= plane_ptr_q[i] +
							AW'(signed'(plane_line_modulo_q[i]));
					end
					state_q <= PFS_IDLE;
				end
				default: state_q <= PFS_IDLE;
			endcase
		end
	end

	// fetched words held until next 16-pixel boundary
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < PFS_NPLANES; i++) begin
				hold_q[i] <= '0;
				shreg_q[i] <= '0;
			end
			pix_cnt_q <= '0;
			line_delay_q <= '0;
		end else begin
			if (line_start) begin
				line_delay_q <= scroll_delay_control_q[7:0];
				pix_cnt_q <= '0;
			end else begin
				pix_cnt_q <= pix_cnt_q + 4'd1;
			end
			for (int i = 0; i < PFS_NPLANES; i++) begin
				if (state_q == PFS_WAIT && mem_ack && plane_q == 3'(i)) begin
					hold_q[i] <= mem_data;
				end
				// extra word loads first, sits left of window
				if (pix_cnt_q == 4'hF) begin
					shreg_q[i] <= hold_q[i];
				end else begin
					shreg_q[i] <= {shreg_q[i][14:0], 1'b0};
				end
			end
		end
	end

	// per-plane delay; odd planes playfield 1, even playfield 2
	generate
		for (genvar g = 0; g < PFS_NPLANES; g++) begin : g_dly
			logic [3:0] d;
			logic [4:0] tap;
			assign d = (g % 2 == 0) ?
				line_delay_q[PFS_PF1_LO +: PFS_DLY_W] :
				line_delay_q[PFS_PF2_LO +: PFS_DLY_W];
			assign tap = ctrl_q[PFS_CTRL_HIRES] ? {d, 1'b0} : {1'b0, d};
			pfs_delay_line #(.DEPTH(32)) u_dly (
				.sys_clk(sys_clk),
				.reset(reset),
				.bit_in(shreg_q[g][15]),
				.tap(tap),
				.bit_out(dly_out[g])
			);
		end
	endgenerate

	// registered pixel output
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pix_out <= '0;
		end else begin
			pix_out <= dly_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request goes out the cycle after the fetch state
	sequence s_fetch_issue;
		state_q == PFS_FETCH ##1 mem_req;
	endsequence
	a_sprite_flag: assert property (
		@(posedge sys_clk) disable iff (reset)
		##1 sprite7_disable == ($past(fetch_start_position_q) <
		PFS_FSTART_NORMAL))
		else $error("sprite 7 flag wrong");
	a_delay_sample: assert property (
		@(posedge sys_clk) disable iff (reset)
		line_start |=> line_delay_q == $past(scroll_delay_control_q[7:0]))
		else $error("delay not sampled at line start");
	a_fetch_window: assert property (
		@(posedge sys_clk) disable iff (reset)
		state_q == PFS_FETCH && plane_q == 3'd0 |-> $past(in_window))
		else $error("burst began outside the fetch window");
	a_fetch_start: assert property (
		@(posedge sys_clk) disable iff (reset)
		state_q == PFS_IDLE && ctrl_q[PFS_CTRL_EN] && in_window && !vblank
		|=> s_fetch_issue)
		else $error("fetch did not start");
	a_ptr_step: assert property (
		@(posedge sys_clk) disable iff (reset)
		state_q == PFS_WAIT && mem_ack && !(aw_got_q && w_got_q)
		|=> plane_ptr_q[$past(plane_q)] ==
		$past(plane_ptr_q[plane_q]) + AW'(2))
		else $error("pointer did not advance");
	a_mod_add: assert property (
		@(posedge sys_clk) disable iff (reset)
		state_q == PFS_MOD && !(aw_got_q && w_got_q) |=>
		plane_ptr_q[0] == $past(plane_ptr_q[0]) +
		AW'(signed'($past(plane_line_modulo_q[0]))))
		else $error("modulo not added");
	a_mod_each: assert property (
		@(posedge sys_clk) disable iff (reset)
		state_q == PFS_MOD && !(aw_got_q && w_got_q) |=>
		plane_ptr_q[5] == $past(plane_ptr_q[5]) +
		AW'(signed'($past(plane_line_modulo_q[5]))))
		else $error("plane 6 modulo not used");
	a_zero_pass: assert property (
		@(posedge sys_clk) disable iff (reset)
		$past(line_delay_q[3:0]) == 4'd0
		|-> pix_out[0] == $past(shreg_q[0][15]))
		else $error("zero delay shifted data");
	a_hires_two: assert property (
		@(posedge sys_clk) disable iff (reset)
		$past(ctrl_q[PFS_CTRL_HIRES]) && $past(line_delay_q[3:0]) == 4'd1
		|-> pix_out[0] == $past(shreg_q[0][15], 3))
		else $error("hires delay step not two");
	a_delay_seven: assert property (
		@(posedge sys_clk) disable iff (reset)
		!$past(ctrl_q[PFS_CTRL_HIRES]) && $past(line_delay_q[3:0]) == 4'd7
		|-> pix_out[0] == $past(shreg_q[0][15], 8))
		else $error("delay of seven not seven pixels");
endmodule : pfs_scroll_fetch
